/* File: core/aefb_consts.vh */
`ifndef AEFB_CONSTS_VH
`define AEFB_CONSTS_VH

`define AEFB_REG_CTRL 4'h0
`define AEFB_REG_SSP 4'h4
`define AEFB_REG_STAT 4'h8
`define AEFB_REG_STATWORD 4'hC
`define AEFB_SSP_RST 32'h0000_1000

`define AEFB_KIND_DATA 2'h0
`define AEFB_KIND_IFETCH 2'h1
`define AEFB_KIND_ADDR 2'h2

`define AEFB_FMT_ACC 4'h7
`define AEFB_FMT_ADR 4'h2
`define AEFB_FMT_SHORT 4'h0
`define AEFB_LEN_ACC 5'h1E
`define AEFB_LEN_ADR 5'h06
`define AEFB_LEN_SHORT 5'h04
`define AEFB_WORD_FMT 5'h03

`define AEFB_VEC_FMTERR 12'h038
`define AEFB_VEC_ACCESS 12'h008

`define AEFB_MOD_UDATA 3'h1
`define AEFB_MOD_UCODE 3'h2
`define AEFB_MOD_SDATA 3'h5
`define AEFB_MOD_SCODE 3'h6

`define AEFB_STATWORD_CONT 15
`define AEFB_STATWORD_XLAT 10

`endif

/* File: core/aefb_frame_builder.v */
// Our own choices: the Wishbone slave port and the register offsets.
`include "aefb_consts.vh"
`default_nettype none

module aefb_frame_builder (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Fault report from the pipeline
    input wire fault_i,
    input wire [1:0] fault_kind_i,
    input wire fault_xlat_i,
    input wire fault_super_i,
    input wire fault_rd_i,
    input wire fault_rmw_i,
    input wire fault_lock_i,
    input wire fault_mis_i,
    input wire [1:0] fault_size_i,
    input wire [1:0] fault_xfer_type_i,
    input wire [2:0] fault_mod_i,
    input wire [3:0] fault_cont_i,
    input wire [31:0] fault_addr_i,
    input wire [31:0] fault_ea_i,
    input wire [11:0] fault_vec_i,
    input wire pending_i,
    // Current processor state
    input wire [15:0] cpu_sr_i,
    input wire [31:0] cpu_pc_i,
    // Pending write-backs, slot 3 in the top bits
    input wire [2:0] wb_pend_i,
    input wire [23:0] wb_stat_i,
    input wire [95:0] wb_addr_i,
    input wire [95:0] wb_data_i,
    input wire [63:0] push_data_i,
    // Return from exception
    input wire ret_i,
    output reg ret_done_o,
    output reg [15:0] ret_sr_o,
    output reg [31:0] ret_pc_o,
    // Handler dispatch
    output reg dispatch_o,
    output reg [11:0] dispatch_vec_o,
    output reg busy_o,
    // Stack memory port
    output reg mem_cyc_o,
    output reg mem_we_o,
    output reg [31:0] mem_adr_o,
    output reg [15:0] mem_dat_o,
    input wire [15:0] mem_dat_i,
    input wire mem_ack_i,
    input wire mem_err_i
);

// =====================================================
// States
localparam S_IDLE = 5'b00001;
localparam S_DRAIN = 5'b00010;
localparam S_PUSH = 5'b00100;
localparam S_RET = 5'b01000;
localparam S_FIN = 5'b10000;

reg [4:0] state;
reg [31:0] ssp;
reg cap_en;
reg fmt_err;
reg val_err;
reg [3:0] last_fmt;

// Latched frame contents
reg [3:0] f_fmt;
reg [15:0] f_sr;
reg [31:0] f_pc;
reg [11:0] f_vec;
reg [31:0] f_ea;
reg [15:0] f_status_word;
reg [31:0] f_addr;
reg [23:0] f_wst;
reg [95:0] f_wad;
reg [95:0] f_wda;
reg [63:0] f_pd;

reg [4:0] idx;
reg [1:0] rstep;
reg [3:0] r_fmt;

// =====================================================
// Fault decode
reg [3:0] cont1;
reg [2:0] mod_fix;
wire is_if = (fault_kind_i == `AEFB_KIND_IFETCH);

always @* begin
    // Keep only the highest continuation request
    if (fault_cont_i[3]) begin
        cont1 = 4'h8;
    end else if (fault_cont_i[2]) begin
        cont1 = 4'h4;
    end else if (fault_cont_i[1]) begin
        cont1 = 4'h2;
    end else if (fault_cont_i[0]) begin
        cont1 = 4'h1;
    end else begin
        cont1 = 4'h0;
    end
    if (is_if) begin
        mod_fix = fault_super_i ? `AEFB_MOD_SCODE : `AEFB_MOD_UCODE;
    end else if (fault_mod_i == `AEFB_MOD_UCODE) begin
        mod_fix = `AEFB_MOD_UDATA;
    end else if (fault_mod_i == `AEFB_MOD_SCODE) begin
        mod_fix = `AEFB_MOD_SDATA;
    end else begin
        mod_fix = fault_mod_i;
    end
end

// Read half of a locked read-modify-write counts as a write
wire rw_flag = fault_rd_i & ~fault_rmw_i;
wire [15:0] next_status_word = {cont1, fault_mis_i, fault_xlat_i, fault_lock_i, rw_flag,
    1'b0, fault_size_i, fault_xfer_type_i, mod_fix};

// =====================================================
// Frame word generator
reg [15:0] fword;
reg [4:0] flen;

always @* begin
    fword = 16'h0000;
    case (f_fmt)
        `AEFB_FMT_ACC: flen = `AEFB_LEN_ACC;
        `AEFB_FMT_ADR: flen = `AEFB_LEN_ADR;
        default: flen = `AEFB_LEN_SHORT;
    endcase
    case (idx)
        5'h00: fword = f_sr;
        5'h01: fword = f_pc[31:16];
        5'h02: fword = f_pc[15:0];
        5'h03: fword = {f_fmt, f_vec};
        5'h04: fword = (f_fmt == `AEFB_FMT_ADR) ? f_addr[31:16] : f_ea[31:16];
        5'h05: fword = (f_fmt == `AEFB_FMT_ADR) ? f_addr[15:0] : f_ea[15:0];
        5'h06: fword = f_status_word;
        5'h07: fword = {8'h00, f_wst[23:16]};
        5'h08: fword = {8'h00, f_wst[15:8]};
        5'h09: fword = {8'h00, f_wst[7:0]};
        5'h0A: fword = f_addr[31:16];
        5'h0B: fword = f_addr[15:0];
        5'h0C: fword = f_wad[95:80];
        5'h0D: fword = f_wad[79:64];
        5'h0E: fword = f_wda[95:80];
        5'h0F: fword = f_wda[79:64];
        5'h10: fword = f_wad[63:48];
        5'h11: fword = f_wad[47:32];
        5'h12: fword = f_wda[63:48];
        5'h13: fword = f_wda[47:32];
        5'h14: fword = f_wad[31:16];
        5'h15: fword = f_wad[15:0];
        5'h16: fword = f_wda[31:16];
        5'h17: fword = f_wda[15:0];
        5'h18: fword = f_pd[63:48];
        5'h19: fword = f_pd[47:32];
        5'h1A: fword = f_pd[31:16];
        5'h1B: fword = f_pd[15:0];
        default: fword = 16'h0000;
    endcase
end

wire [31:0] flen_b = {26'h0, flen, 1'b0};
reg [4:0] rlen;

always @* begin
    case (r_fmt)
        `AEFB_FMT_ACC: rlen = `AEFB_LEN_ACC;
        `AEFB_FMT_ADR: rlen = `AEFB_LEN_ADR;
        default: rlen = `AEFB_LEN_SHORT;
    endcase
end

wire fmt_ok = (mem_dat_i[15:12] == `AEFB_FMT_ACC) ||
    (mem_dat_i[15:12] == `AEFB_FMT_ADR) ||
    (mem_dat_i[15:12] == `AEFB_FMT_SHORT);
wire [1:0] n_rstep = rstep + 2'h1;
wire [4:0] rd_idx = (rstep == 2'h0) ? `AEFB_WORD_FMT : {3'h0, rstep - 2'h1};

// =====================================================
// Wishbone slave
wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_hit & wb_we_i;

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        cap_en <= 1'b0;
    end else begin
        wb_ack_o <= wb_hit;
        wb_dat_o <= 32'h0000_0000;
        if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                `AEFB_REG_CTRL: wb_dat_o <= {31'h0, cap_en};
                `AEFB_REG_SSP: wb_dat_o <= ssp;
                `AEFB_REG_STAT: wb_dat_o <= {24'h0, last_fmt, 1'b0, val_err, fmt_err, busy_o};
                `AEFB_REG_STATWORD: wb_dat_o <= {16'h0, f_status_word};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
        if (wb_wr && wb_adr_i == `AEFB_REG_CTRL && wb_sel_i[0]) begin
            cap_en <= wb_dat_i[0];
        end
    end
end

// =====================================================
// Frame engine
always @(posedge clk_i) begin
    if (rst_i) begin
        state <= S_IDLE;
        ssp <= `AEFB_SSP_RST;
        fmt_err <= 1'b0;
        val_err <= 1'b0;
        last_fmt <= 4'h0;
        f_fmt <= 4'h0;
        f_sr <= 16'h0000;
        f_pc <= 32'h0000_0000;
        f_vec <= 12'h000;
        f_ea <= 32'h0000_0000;
        f_status_word <= 16'h0000;
        f_addr <= 32'h0000_0000;
        f_wst <= 24'h00_0000;
        f_wad <= 96'h0;
        f_wda <= 96'h0;
        f_pd <= 64'h0;
        idx <= 5'h00;
        rstep <= 2'h0;
        r_fmt <= 4'h0;
        ret_done_o <= 1'b0;
        ret_sr_o <= 16'h0000;
        ret_pc_o <= 32'h0000_0000;
        dispatch_o <= 1'b0;
        dispatch_vec_o <= 12'h000;
        busy_o <= 1'b0;
        mem_cyc_o <= 1'b0;
        mem_we_o <= 1'b0;
        mem_adr_o <= 32'h0000_0000;
        mem_dat_o <= 16'h0000;
    end else begin
        ret_done_o <= 1'b0;
        dispatch_o <= 1'b0;
        // Sticky error flags: a new error in the clearing cycle survives
        if (wb_wr && wb_adr_i == `AEFB_REG_STAT && wb_sel_i[0]) begin
            if (wb_dat_i[1]) begin
                fmt_err <= 1'b0;
            end
            if (wb_dat_i[2]) begin
                val_err <= 1'b0;
            end
        end
        if (wb_wr && wb_adr_i == `AEFB_REG_SSP && !busy_o) begin
            ssp <= wb_dat_i;
        end
        case (state)
            S_IDLE: begin
                idx <= 5'h00;
                rstep <= 2'h0;
                if (fault_i && cap_en) begin
                    busy_o <= 1'b1;
                    f_sr <= cpu_sr_i;
                    f_pc <= cpu_pc_i;
                    f_vec <= fault_vec_i;
                    f_status_word <= next_status_word;
                    f_ea <= (cont1 != 4'h0) ? fault_ea_i : 32'h0000_0000;
                    f_pd <= push_data_i;
                    if (fault_kind_i == `AEFB_KIND_ADDR) begin
                        f_fmt <= `AEFB_FMT_ADR;
                        f_addr <= {fault_addr_i[31:1], 1'b0};
                    end else begin
                        f_fmt <= `AEFB_FMT_ACC;
                        f_addr <= fault_addr_i;
                    end
                    if (is_if || fault_kind_i == `AEFB_KIND_ADDR) begin
                        // Prefetch and address error faults never carry write-backs
                        f_wst <= 24'h00_0000;
                        f_wad <= 96'h0;
                        f_wda <= 96'h0;
                    end else begin
                        f_wst <= {wb_pend_i[2] ? wb_stat_i[23:16] : 8'h00,
                            wb_pend_i[1] ? wb_stat_i[15:8] : 8'h00,
                            wb_pend_i[0] ? wb_stat_i[7:0] : 8'h00};
                        f_wad <= wb_addr_i;
                        f_wda <= wb_data_i;
                    end
                    state <= S_DRAIN;
                end else if (ret_i) begin
                    busy_o <= 1'b1;
                    state <= S_RET;
                end
            end
            S_DRAIN: begin
                // Prefetch faults wait for outstanding accesses
                if (!(f_fmt == `AEFB_FMT_ACC && pending_i &&
                    (f_status_word[2:0] == `AEFB_MOD_UCODE ||
                    f_status_word[2:0] == `AEFB_MOD_SCODE))) begin
                    ssp <= ssp - flen_b;
                    state <= S_PUSH;
                end
            end
            S_PUSH: begin
                if (!mem_cyc_o) begin
                    mem_cyc_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_adr_o <= ssp + {26'h0, idx, 1'b0};
                    mem_dat_o <= fword;
                end else if (mem_ack_i || mem_err_i) begin
                    mem_cyc_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    idx <= idx + 5'h01;
                    if (idx == flen - 5'h01) begin
                        state <= S_FIN;
                    end
                end
            end
            S_RET: begin
                if (!mem_cyc_o) begin
                    mem_cyc_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_adr_o <= ssp + {26'h0, rd_idx, 1'b0};
                end else if (mem_err_i) begin
                    // Fault while reading the frame: new frame below it
                    mem_cyc_o <= 1'b0;
                    val_err <= 1'b1;
                    f_fmt <= `AEFB_FMT_ACC;
                    f_sr <= cpu_sr_i;
                    f_pc <= cpu_pc_i;
                    f_vec <= `AEFB_VEC_ACCESS;
                    f_status_word <= {8'h01, 5'h00, `AEFB_MOD_SDATA};
                    f_ea <= 32'h0000_0000;
                    f_addr <= mem_adr_o;
                    f_wst <= 24'h00_0000;
                    f_wad <= 96'h0;
                    f_wda <= 96'h0;
                    f_pd <= 64'h0;
                    state <= S_DRAIN;
                end else if (mem_ack_i) begin
                    mem_cyc_o <= 1'b0;
                    rstep <= n_rstep;
                    if (rstep == 2'h0) begin
                        r_fmt <= mem_dat_i[15:12];
                        if (!fmt_ok) begin
                            // Illegal format: stack a short frame, leave the bad one
                            fmt_err <= 1'b1;
                            f_fmt <= `AEFB_FMT_SHORT;
                            f_sr <= cpu_sr_i;
                            f_pc <= cpu_pc_i;
                            f_vec <= `AEFB_VEC_FMTERR;
                            state <= S_DRAIN;
                        end
                    end else if (rstep == 2'h1) begin
                        ret_sr_o <= mem_dat_i;
                    end else if (rstep == 2'h2) begin
                        ret_pc_o[31:16] <= mem_dat_i;
                    end else begin
                        // Stacked PC restarts the faulted instruction
                        ret_pc_o[15:0] <= mem_dat_i;
                        ssp <= ssp + {26'h0, rlen, 1'b0};
                        last_fmt <= r_fmt;
                        ret_done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state <= S_IDLE;
                    end
                end
            end
            S_FIN: begin
                dispatch_o <= 1'b1;
                dispatch_vec_o <= f_vec;
                last_fmt <= f_fmt;
                busy_o <= 1'b0;
                state <= S_IDLE;
            end
            default: state <= S_IDLE;
        endcase
    end
end

endmodule // aefb_frame_builder

`default_nettype wire

/* File: sim/aefb_frame_checker_asserts.sv */
`default_nettype none
// ====================
// Frame builder checker
module aefb_frame_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fault and return requests
    input wire logic fault_i,
    input wire logic [1:0] fault_kind_i,
    input wire logic fault_xlat_i,
    input wire logic fault_super_i,
    input wire logic [3:0] fault_cont_i,
    input wire logic pending_i,
    input wire logic ret_i,
    // Dispatch and stack port
    input wire logic dispatch_o,
    input wire logic busy_o,
    input wire logic mem_cyc_o,
    input wire logic mem_we_o,
    input wire logic [15:0] mem_dat_o,
    input wire logic mem_ack_i,
    input wire logic mem_err_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] kind;
    logic sup, xl, noc;
    logic [5:0] nwr;
    // Kind 3 marks a frame started by a return; nwr is the index of the word in flight
    always @(posedge clk_i) begin
        if (rst_i) begin
            kind <= 2'h3;
            nwr <= 6'h00;
        end else if (!busy_o && (fault_i || ret_i)) begin
            kind <= fault_i ? fault_kind_i : 2'h3;
            sup <= fault_super_i;
            xl <= fault_xlat_i;
            noc <= (fault_cont_i == 4'h0);
            nwr <= 6'h00;
        end else if (mem_cyc_o && mem_we_o && (mem_ack_i || mem_err_i)) begin
            nwr <= nwr + 6'h01;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_word(int n);
        mem_cyc_o && mem_we_o && nwr == n;
    endsequence
    sequence s_stat_word;
        s_word(6) ##0 !kind[1];
    endsequence
    sequence s_fetch_wait;
        kind == 2'h1 && busy_o && pending_i && !mem_cyc_o;
    endsequence
    AST_ACC_LEN: assert property (dispatch_o && !kind[1] |-> nwr == 6'h1E)
        else $error("Access frame length wrong");
    AST_ADR_LEN: assert property (dispatch_o && kind == 2'h2 |-> nwr == 6'h06)
        else $error("Address error frame length wrong");
    AST_VAL_LEN: assert property (dispatch_o && kind == 2'h3 |-> nwr inside {6'h04, 6'h1E})
        else $error("Return fault frame length wrong");
    AST_FMT_WORD: assert property (s_word(3) ##0 !kind[1] |-> mem_dat_o[15:12] == 4'h7)
        else $error("Format nibble wrong");
    AST_STAT_HI: assert property (mem_cyc_o && mem_we_o && !kind[1] && nwr >= 7 && nwr <= 9
        |-> mem_dat_o[15:8] == 8'h00)
        else $error("Write-back status upper byte not zero");
    AST_EA_VALID: assert property (mem_cyc_o && mem_we_o && !kind[1] && noc
        && (nwr == 4 || nwr == 5) |-> mem_dat_o == 16'h0000)
        else $error("Effective address stored without continuation");
    AST_ONE_CONT: assert property (s_stat_word |-> $countones(mem_dat_o[15:12]) <= 1)
        else $error("Several continuation flags");
    AST_MOD_FETCH: assert property (s_stat_word ##0 kind == 2'h1
        |-> mem_dat_o[2:0] == {sup, 2'h2})
        else $error("Fetch modifier wrong");
    AST_XLAT_FLAG: assert property (s_stat_word |-> mem_dat_o[10] == xl)
        else $error("Translation flag wrong");
    AST_FETCH_NOWB: assert property (mem_cyc_o && mem_we_o && kind == 2'h1
        && nwr >= 12 && nwr <= 23 |-> mem_dat_o == 16'h0000)
        else $error("Fetch frame holds write-backs");
    AST_FETCH_DRAIN: assert property (s_fetch_wait |=> !mem_cyc_o)
        else $error("Fetch frame pushed while accesses pending");
    AST_ADR_BIT0: assert property (s_word(5) ##0 kind == 2'h2 |-> !mem_dat_o[0])
        else $error("Address bit 0 not cleared");
endmodule // aefb_frame_checker

bind aefb_frame_builder aefb_frame_checker chk (.*);
`default_nettype wire

/* File: sim/aefb_stack_mem.sv */
`default_nettype none
// ====================
// Supervisor stack memory
module aefb_stack_mem (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Stack port
    input wire logic cyc_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [15:0] dat_i,
    output logic [15:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Test controls
    input wire logic [3:0] delay_i,
    input wire logic [31:0] err_adr_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ram [0:4095];
    logic [3:0] cnt;
    // Idle data toggles so a late sample never looks valid
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        err_o <= 1'b0;
        dat_o <= ~dat_o;
        if (rst_i) begin
            cnt <= 4'h0;
            dat_o <= 16'h0000;
        end else if (cyc_i && !ack_o && !err_o) begin
            cnt <= cnt + 4'h1;
            if (cnt == delay_i) begin
                cnt <= 4'h0;
                if (!we_i && adr_i == err_adr_i)
                    err_o <= 1'b1;
                else
                    ack_o <= 1'b1;
                if (we_i)
                    ram[adr_i[12:1]] <= dat_i;
                else
                    dat_o <= ram[adr_i[12:1]];
            end
        end
    end
endmodule // aefb_stack_mem
`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none
`define CHK(a, e) begin \
    n_tests++; \
    if ((a) !== (e)) begin \
        n_fail++; \
        $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Signals
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fault_i, fault_xlat_i;
    logic fault_super_i, fault_rd_i, fault_rmw_i, fault_lock_i, fault_mis_i, pending_i;
    logic ret_i, ret_done_o, dispatch_o, busy_o, mem_cyc_o, mem_we_o, mem_ack_i, mem_err_i;
    logic [1:0] fault_kind_i, fault_size_i, fault_xfer_type_i;
    logic [2:0] fault_mod_i, wb_pend_i;
    logic [3:0] wb_adr_i, wb_sel_i, fault_cont_i, dly;
    logic [11:0] fault_vec_i, dispatch_vec_o;
    logic [15:0] cpu_sr_i, ret_sr_o, mem_dat_o, mem_dat_i;
    logic [23:0] wb_stat_i;
    logic [31:0] wb_dat_i, wb_dat_o, fault_addr_i, fault_ea_i, cpu_pc_i, ret_pc_o, mem_adr_o;
    logic [31:0] err_adr, ssp, q;
    logic [63:0] push_data_i;
    logic [95:0] wb_addr_i, wb_data_i;
    int n_fail, n_tests;
    aefb_frame_builder DUT (.*);
    aefb_stack_mem mem (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(mem_cyc_o), .we_i(mem_we_o),
        .adr_i(mem_adr_o), .dat_i(mem_dat_o), .dat_o(mem_dat_i), .ack_o(mem_ack_i),
        .err_o(mem_err_i), .delay_i(dly), .err_adr_i(err_adr));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ====================
    // Shared tasks
    function automatic logic [15:0] wd(input int i);
        return mem.ram[ssp[12:1] + i];
    endfunction
    task automatic conclude;
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(input logic ok);
        if (!ok) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        tmo(wb_ack_o === 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        wb(1'b0, a, 32'h0);
    endtask
    // Waits for a dispatch or a finished return, whichever comes
    task automatic wait_end(output logic d);
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (dispatch_o !== 1'b1 && ret_done_o !== 1'b1 && k < 600);
        tmo(dispatch_o === 1'b1 || ret_done_o === 1'b1);
        d = (dispatch_o === 1'b1);
    endtask
    // Pending stays up a while so fetch faults have something to drain
    task automatic fault(input logic [1:0] k, input logic s, input logic x, input logic [3:0] c);
        fault_kind_i <= k;
        fault_super_i <= s;
        fault_xlat_i <= x;
        fault_cont_i <= c;
        fault_rmw_i <= (k == 2'h0);
        fault_mod_i <= {s, 2'h2};
        fault_i <= 1'b1;
        pending_i <= 1'b1;
        @(posedge clk_i);
        fault_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        pending_i <= 1'b0;
    endtask
    task automatic ret;
        ret_i <= 1'b1;
        @(posedge clk_i);
        ret_i <= 1'b0;
    endtask
    // ====================
    // Scenarios
    task automatic regs;
        rd(4'h0);
        `CHK(q, 32'h0)
        rd(4'h4);
        `CHK(q, 32'h1000)
        wb(1'b1, 4'h2, 32'hFFFF_FFFF);
        rd(4'h2);
        `CHK(q, 32'h0)
        wb(1'b1, 4'h0, 32'h1);
        rd(4'h0);
        `CHK(q, 32'h1)
    endtask
    task automatic acc_case(input logic [1:0] k, input logic s, input logic x,
            input logic [3:0] c, input logic [3:0] kept);
        logic d;
        logic f;
        logic [7:0] es;
        logic [15:0] ew;
        logic [31:0] old;
        rd(4'h4);
        old = q;
        f = (k == 2'h1);
        fault(k, s, x, c);
        wait_end(d);
        `CHK(d, 1'b1)
        `CHK(dispatch_vec_o, fault_vec_i)
        rd(4'h4);
        ssp = q;
        `CHK(ssp, old - 32'h3C)
        `CHK(wd(0), cpu_sr_i)
        `CHK({wd(1), wd(2)}, cpu_pc_i)
        `CHK(wd(3), {4'h7, fault_vec_i})
        `CHK({wd(4), wd(5)}, (c == 4'h0) ? 32'h0 : fault_ea_i)
        `CHK(busy_o, 1'b0)
        ew = {kept, fault_mis_i, x, fault_lock_i, f, 1'b0, fault_size_i, fault_xfer_type_i, s, f, !f};
        `CHK(wd(6), ew)
        for (int j = 0; j < 3; j++) begin
            es = (f || !wb_pend_i[2-j]) ? 8'h00 : wb_stat_i[16-8*j +: 8];
            `CHK(wd(7 + j), {8'h00, es})
            `CHK({wd(12 + 4*j), wd(13 + 4*j)}, f ? 32'h0 : wb_addr_i[64-32*j +: 32])
            `CHK({wd(14 + 4*j), wd(15 + 4*j)}, f ? 32'h0 : wb_data_i[64-32*j +: 32])
        end
        `CHK({wd(10), wd(11)}, fault_addr_i)
        if (!f)
            `CHK({wd(24), wd(25), wd(26), wd(27)}, push_data_i)
        rd(4'hC);
        `CHK(q, {16'h0, ew})
    endtask
    task automatic adr_case;
        logic d;
        logic [31:0] old;
        rd(4'h4);
        old = q;
        fault(2'h2, 1'b1, 1'b0, 4'h0);
        wait_end(d);
        rd(4'h4);
        ssp = q;
        `CHK(ssp, old - 32'h0C)
        `CHK({wd(1), wd(2)}, cpu_pc_i)
        `CHK(wd(3), {4'h2, fault_vec_i})
        `CHK({wd(4), wd(5)}, fault_addr_i & 32'hFFFF_FFFE)
    endtask
    task automatic ret_ok(input logic [31:0] n);
        logic d;
        logic [31:0] old;
        rd(4'h4);
        old = q;
        ret();
        wait_end(d);
        `CHK(d, 1'b0)
        `CHK(ret_sr_o, cpu_sr_i)
        `CHK(ret_pc_o, cpu_pc_i)
        rd(4'h4);
        `CHK(q, old + n)
    endtask
    // Bad format first, then a read error while the new short frame is checked
    task automatic bad_fmt;
        logic d;
        logic [31:0] old;
        rd(4'h4);
        old = q;
        mem.ram[old[12:1] + 3] = 16'h5000;
        ret();
        wait_end(d);
        `CHK(dispatch_vec_o, 12'h038)
        `CHK(mem.ram[old[12:1] + 3], 16'h5000)
        rd(4'h4);
        ssp = q;
        `CHK(ssp, old - 32'h08)
        `CHK(wd(3), 16'h0038)
        rd(4'h8);
        `CHK(q[7:0], 8'h02)
        wb(1'b1, 4'h8, 32'h2);
        rd(4'h8);
        `CHK(q[2:1], 2'h0)
        err_adr <= ssp + 32'h6;
        ret();
        wait_end(d);
        `CHK(dispatch_vec_o, 12'h008)
        rd(4'h8);
        `CHK(q[7:0], 8'h74)
        rd(4'h4);
        old = ssp;
        ssp = q;
        `CHK(ssp, old - 32'h3C)
        `CHK({wd(10), wd(11)}, old + 32'h6)
        `CHK(wd(6), 16'h0105)
    endtask
    // ====================
    // Main sequence
    initial begin
        n_fail = 0;
        n_tests = 0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, fault_i, ret_i, pending_i} = 7'h40;
        {fault_xlat_i, fault_super_i, fault_rmw_i, fault_kind_i, fault_cont_i} = 9'h000;
        {fault_rd_i, fault_lock_i, fault_mis_i} = 3'h7;
        {fault_size_i, fault_xfer_type_i, fault_mod_i} = 7'h22;
        {wb_adr_i, wb_sel_i, wb_dat_i, dly, err_adr} = {4'h0, 4'hF, 32'h0, 4'h0, 32'hFFFF_FFFF};
        {cpu_sr_i, cpu_pc_i, fault_vec_i} = {16'h2704, 32'h0000_4A10, 12'h008};
        {fault_addr_i, fault_ea_i} = {32'h1234_5677, 32'h0ABC_DE10};
        {wb_pend_i, wb_stat_i, push_data_i} = {3'h7, 24'h352515, 64'h1111_2222_3333_4444};
        wb_addr_i = {32'h3000_0030, 32'h2000_0020, 32'h1000_0010};
        wb_data_i = {32'hC3C3_0003, 32'hB2B2_0002, 32'hA1A1_0001};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        regs();
        dly <= 4'h3;
        acc_case(2'h0, 1'b1, 1'b1, 4'h3, 4'h2);
        dly <= 4'h0;
        wb_pend_i <= 3'h5;
        acc_case(2'h0, 1'b0, 1'b0, 4'hC, 4'h8);
        acc_case(2'h1, 1'b0, 1'b0, 4'h0, 4'h0);
        acc_case(2'h1, 1'b1, 1'b1, 4'h0, 4'h0);
        adr_case();
        ret_ok(32'h0C);
        ret_ok(32'h3C);
        bad_fmt();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
